/* File: core/vic_pkg.sv */
// Shared constants, types and helpers of the vectored interrupt controller
package vic_pkg;

  // ---------------------------------------------------------------
  // Table geometry
  // ---------------------------------------------------------------
  localparam int          NUM_TRAP     = 8;            // Non-maskable trap slots
  localparam int          NUM_IRQ      = 118;          // Maskable request slots
  localparam int          NUM_VEC      = 126;          // Entries per table
  localparam int          VEC_W        = 7;            // Vector number width
  localparam int          LVL_W        = 4;            // CPU level width incl. trap bit
  localparam int          PRIO_W       = 3;            // Per-source priority field
  localparam int          ADDR_W       = 24;           // Program address width
  localparam int          IDX_W        = 8;            // Memory index: table bit + vector
  localparam logic [6:0]  IRQ_VEC_BASE = 7'h08;        // Request number to vector offset
  localparam logic [23:0] PRI_BASE     = 24'h000004;   // Primary table start
  localparam logic [23:0] ALT_OFFSET   = 24'h000100;   // Alternate entry distance
  localparam logic [23:0] RESET_PC     = 24'h000000;   // Fetch start after reset
  localparam logic [3:0]  TRAP_LEVEL   = 4'h8;         // Trap level, above any user level
  localparam logic [3:0]  BLOCK_LEVEL  = 4'h7;         // CPU level that masks all users
  localparam int          ALT_BIT      = 15;           // Select bit in control word two

  // ---------------------------------------------------------------
  // Implemented sources
  // ---------------------------------------------------------------
  localparam logic [7:0]   TRAP_IMPL = 8'h1E;          // Osc fail, address, stack, math
  localparam logic [117:0] IRQ_IMPL  =
    {22'h000000, 32'h00010106, 32'h00060020, 32'hEA1FB9CD};
  localparam int           EXT0_IRQ  = 0;              // External request zero
  localparam int           EXT1_IRQ  = 20;             // External request one
  localparam int           EXT2_IRQ  = 29;             // External request two

  // ---------------------------------------------------------------
  // Fixed latencies in clock cycles
  // ---------------------------------------------------------------
  localparam int ENTRY_CYC = 2;                        // Acknowledge to vector valid
  localparam int RET_CYC   = 1;                        // Return request edge to done pulse

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ENTRY   = 4'b0010,
    ST_DELIVER = 4'b0100,
    ST_RETURN  = 4'b1000
  } vic_state_t;

  typedef struct packed {
    logic [6:0] taken_vector_number;                                // Winning vector number
    logic [3:0] level;                                 // New CPU level
  } vic_take_t;

  // Program address of a vector entry in either table
  function automatic logic [23:0] vic_vec_addr(input logic [6:0] num, input logic alt);
    logic [23:0] base;
    base = alt ? (PRI_BASE + ALT_OFFSET) : PRI_BASE;
    return base + {16'h0000, num, 1'b0};
  endfunction

endpackage

/* File: core/vic_vector_mem.sv */
// Vector entry store for both tables, registered read port
module vic_vector_mem
  import vic_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       wrEn,
  input  wire logic [vic_pkg::IDX_W-1:0]  wrIdx,
  input  wire logic [vic_pkg::ADDR_W-1:0] wrData,
  input  wire logic [vic_pkg::IDX_W-1:0]  rdIdx,
  output logic      [vic_pkg::ADDR_W-1:0] rdData
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Upper index bit picks the table; contents are software's job
  logic [ADDR_W-1:0] memArr [0:(1<<IDX_W)-1];

  // No reset on the array: keeps it a plain RAM for synthesis
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      memArr[wrIdx] <= wrData;
    end
    rdData <= memArr[rdIdx];
  end

endmodule

/* File: core/vic_controller.sv */
// Vectored interrupt controller: flags, arbitration and vector delivery
module vic_controller
  import vic_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire logic [vic_pkg::NUM_IRQ-1:0] srcEvent,
  input  wire logic [2:0]                  extPin,
  input  wire logic [vic_pkg::NUM_IRQ-1:0] flagClr,
  input  wire logic [vic_pkg::NUM_IRQ-1:0] srcEnable,
  input  wire logic [vic_pkg::NUM_IRQ-1:0][2:0] srcPriority,
  input  wire logic [7:0]                  trapEvent,
  input  wire logic [7:0]                  trapClr,
  input  wire logic [15:0]                 interruptControlTwo,
  input  wire logic [3:0]                  cpuPriorityLevel,
  input  wire logic                        cpuAck,
  input  wire logic                        retReq,
  input  wire logic                        tblWrEn,
  input  wire logic [vic_pkg::IDX_W-1:0]   tblWrIdx,
  input  wire logic [vic_pkg::ADDR_W-1:0]  tblWrData,
  output logic                             intReq,
  output logic                             vecValid,
  output logic      [vic_pkg::ADDR_W-1:0]  vecAddr,
  output logic      [vic_pkg::ADDR_W-1:0]  vecEntry,
  output logic                             retDone,
  output vic_pkg::vic_take_t               takenVectorStatus,
  output logic      [vic_pkg::NUM_IRQ-1:0] requestFlagRegs,
  output logic      [7:0]                  trapFlags
);

  // ---------------------------------------------------------------
  // External pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] extMeta_ff, extSync_ff, extLast_ff;     // Two-stage sync plus history
  logic [2:0] nxt_extMeta, nxt_extSync, nxt_extLast;
  logic [NUM_IRQ-1:0] extEvent;                        // Rising edges at request slots

  always_comb begin
    nxt_extMeta = extPin;
    nxt_extSync = extMeta_ff;
    nxt_extLast = extSync_ff;
    extEvent    = '0;
    // Only the second stage and its history feed the edge detector
    extEvent[EXT0_IRQ] = extSync_ff[0] & ~extLast_ff[0];
    extEvent[EXT1_IRQ] = extSync_ff[1] & ~extLast_ff[1];
    extEvent[EXT2_IRQ] = extSync_ff[2] & ~extLast_ff[2];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extMeta_ff <= 3'h0;
      extSync_ff <= 3'h0;
      extLast_ff <= 3'h0;
    end else begin
      extMeta_ff <= nxt_extMeta;
      extSync_ff <= nxt_extSync;
      extLast_ff <= nxt_extLast;
    end
  end

  // ---------------------------------------------------------------
  // Sticky request and trap flags
  // ---------------------------------------------------------------
  logic [NUM_IRQ-1:0] flags_ff, nxt_flags;            // Maskable request flags
  logic [7:0]         traps_ff, nxt_traps;            // Trap status flags

  // Set wins over a clear in the same cycle; unimplemented slots stay zero
  always_comb begin
    nxt_flags = ((flags_ff & ~flagClr) | srcEvent | extEvent) & IRQ_IMPL;
    nxt_traps = ((traps_ff & ~trapClr) | trapEvent) & TRAP_IMPL;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= '0;
      traps_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      traps_ff <= nxt_traps;
    end
  end

  assign requestFlagRegs = flags_ff;
  assign trapFlags       = traps_ff;

  // ---------------------------------------------------------------
  // Per-vector qualification
  // ---------------------------------------------------------------
  logic [NUM_VEC-1:0]       vecQual;                  // Vector may win this cycle
  logic [NUM_VEC-1:0][3:0]  vecLvl;                   // Effective level of vector

  for (genvar v = 0; v < NUM_VEC; v++) begin : g_qual
    if (v < NUM_TRAP) begin : g_trap
      // Traps sit above every user level and ignore the CPU level
      assign vecQual[v] = traps_ff[v];
      assign vecLvl[v]  = TRAP_LEVEL;
    end else begin : g_irq
      // Request n lands on vector n plus 8; priority zero never passes
      assign vecLvl[v]  = {1'b0, srcPriority[v-NUM_TRAP]};
      assign vecQual[v] = flags_ff[v-NUM_TRAP] & srcEnable[v-NUM_TRAP]
                          & (vecLvl[v] > cpuPriorityLevel);
    end
  end

  // ---------------------------------------------------------------
  // Winner selection
  // ---------------------------------------------------------------
  logic       anyQual;                                 // Something may be taken
  logic [6:0] winVec;                                  // Winning vector number
  logic [3:0] winLvl;                                  // Its level

  // Scan from the top down with >= so the lowest vector keeps a tie;
  // no rotation, so the order never depends on history
  always_comb begin
    anyQual = 1'b0;
    winVec  = 7'h00;
    winLvl  = 4'h0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (vecQual[v] && (!anyQual || vecLvl[v] >= winLvl)) begin
        anyQual = 1'b1;
        winVec  = 7'(v);
        winLvl  = vecLvl[v];
      end
    end
  end

  // ---------------------------------------------------------------
  // Request, sequencing and taken status
  // ---------------------------------------------------------------
  vic_state_t  state_ff, nxt_state;                    // Entry/return sequencer
  logic        req_ff, nxt_req;                        // Registered CPU request
  vic_take_t   taken_ff, nxt_taken;                    // Latched vector and level
  logic        alt_ff, nxt_alt;                        // Table chosen at take
  logic [23:0] addr_ff, nxt_addr;                      // Entry address presented
  logic [23:0] entry_ff, nxt_entry;                    // Entry contents delivered
  logic        take;                                   // Acknowledge accepted
  logic [23:0] memData;                                // Registered memory read

  assign take = (state_ff == ST_IDLE) && cpuAck && req_ff && anyQual;

  always_comb begin
    nxt_state = state_ff;
    nxt_req   = anyQual;
    nxt_taken = taken_ff;
    nxt_alt   = alt_ff;
    nxt_addr  = addr_ff;
    nxt_entry = entry_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          // Latch winner and table selection at the acknowledge
          nxt_taken.taken_vector_number = winVec;
          nxt_taken.level  = winLvl;
          nxt_alt          = interruptControlTwo[ALT_BIT];
          nxt_addr         = vic_vec_addr(winVec, interruptControlTwo[ALT_BIT]);
          nxt_state        = ST_ENTRY;
        end else if (retReq) begin
          nxt_state = ST_RETURN;
        end
      end
      ST_ENTRY: begin
        // Memory word is ready now; same length for every source
        nxt_entry = memData;
        nxt_state = ST_DELIVER;
      end
      ST_DELIVER: begin
        nxt_state = ST_IDLE;
      end
      ST_RETURN: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Reset clears the sequencer registers and points the fetch address at zero;
  // no vector is involved in getting the CPU started
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      req_ff   <= 1'b0;
      taken_ff <= '0;
      alt_ff   <= 1'b0;
      addr_ff  <= RESET_PC;
      entry_ff <= RESET_PC;
    end else begin
      state_ff <= nxt_state;
      req_ff   <= nxt_req;
      taken_ff <= nxt_taken;
      alt_ff   <= nxt_alt;
      addr_ff  <= nxt_addr;
      entry_ff <= nxt_entry;
    end
  end

  assign intReq            = req_ff;
  assign vecValid          = (state_ff == ST_DELIVER);
  assign retDone           = (state_ff == ST_RETURN);
  assign vecAddr           = addr_ff;
  assign vecEntry          = entry_ff;
  assign takenVectorStatus = taken_ff;

  // ---------------------------------------------------------------
  // Vector table storage
  // ---------------------------------------------------------------
  // Read is launched in the take cycle so latency never varies
  vic_vector_mem vic_vector_mem_inst (
    .sys_clk (sys_clk),
    .wrEn    (tblWrEn),
    .wrIdx   (tblWrIdx),
    .wrData  (tblWrData),
    .rdIdx   ({interruptControlTwo[ALT_BIT], winVec}),
    .rdData  (memData)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_take;
    state_ff == ST_IDLE && cpuAck && req_ff && anyQual;
  endsequence

  sequence s_ret;
    state_ff == ST_IDLE && retReq && !(cpuAck && req_ff && anyQual);
  endsequence

  property p_reqFollows;
    @(posedge sys_clk) disable iff (!nrst) intReq == $past(anyQual);
  endproperty
  a_reqFollows: assert property (p_reqFollows) else $error("request not following qualification");

  property p_entryLat;
    @(posedge sys_clk) disable iff (!nrst) s_take |-> !vecValid ##1 !vecValid ##1 vecValid;
  endproperty
  a_entryLat: assert property (p_entryLat) else $error("entry latency wrong");

  property p_retLat;
    @(posedge sys_clk) disable iff (!nrst) s_ret |=> retDone ##1 !retDone;
  endproperty
  a_retLat: assert property (p_retLat) else $error("return latency wrong");

  property p_addrMap;
    @(posedge sys_clk) disable iff (!nrst)
      s_take |-> ##2 vecAddr == vic_vec_addr($past(winVec, 2), $past(interruptControlTwo[ALT_BIT], 2));
  endproperty
  a_addrMap: assert property (p_addrMap) else $error("vector address wrong");

  property p_altTable;
    @(posedge sys_clk) disable iff (!nrst) vecValid |-> vecAddr[8] == alt_ff;
  endproperty
  a_altTable: assert property (p_altTable) else $error("table select ignored");

  property p_sticky;
    @(posedge sys_clk) disable iff (!nrst)
      ($past(flags_ff) & ~$past(flagClr) & ~flags_ff) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_unimpl;
    @(posedge sys_clk) disable iff (!nrst) (flags_ff & ~IRQ_IMPL) == '0 && (traps_ff & ~TRAP_IMPL) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented source flagged");

  property p_blocked;
    @(posedge sys_clk) disable iff (!nrst)
      cpuPriorityLevel >= BLOCK_LEVEL && traps_ff == 8'h00 |-> !anyQual;
  endproperty
  a_blocked: assert property (p_blocked) else $error("user request above level 7");

  property p_trapFirst;
    @(posedge sys_clk) disable iff (!nrst) traps_ff != 8'h00 |-> anyQual && winVec < IRQ_VEC_BASE;
  endproperty
  a_trapFirst: assert property (p_trapFirst) else $error("trap lost arbitration");

  property p_takenLatch;
    @(posedge sys_clk) disable iff (!nrst)
      s_take |=> takenVectorStatus.taken_vector_number == $past(winVec) && takenVectorStatus.level == $past(winLvl);
  endproperty
  a_takenLatch: assert property (p_takenLatch) else $error("taken status not latched");

endmodule

/* File: bench/vic_cpu_model.sv */
// Behavioural CPU core that accepts requests, waits for vector valid and returns
module vic_cpu_model
  import vic_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic intReq,
  input  wire logic vecValid,
  input  wire logic retDone,
  output logic      cpuAck,
  output logic      retReq
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle until the bench asks for a transfer
  initial begin
    cpuAck = 1'b0;
    retReq = 1'b0;
  end

  // Accept a pending request after dly cycles; lat counts cycles to the vector
  task automatic take(input int dly, output int lat);
    int n;
    n = 0;
    while (intReq !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (dly) @(posedge sys_clk);
    @(posedge sys_clk);
    cpuAck <= 1'b1;
    @(posedge sys_clk);
    cpuAck <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (vecValid !== 1'b1 && lat < 12);
  endtask

  // Leave the handler; lat counts cycles to the done pulse
  task automatic ret(output int lat);
    @(posedge sys_clk);
    retReq <= 1'b1;
    @(posedge sys_clk);
    retReq <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (retDone !== 1'b1 && lat < 12);
  endtask
endmodule

/* File: bench/vectored_interrupt_controller_tb.sv */
// Self-checking bench of the vectored interrupt controller
`define vic_chk(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module vectored_interrupt_controller_tb
  import vic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                    sys_clk = 1'b0;
  logic                    nrst, cpuAck, retReq, intReq, vecValid, retDone, tblWrEn;
  logic [NUM_IRQ-1:0]      srcEvent, flagClr, srcEnable, requestFlagRegs;
  logic [NUM_IRQ-1:0][2:0] srcPriority;
  logic [2:0]              extPin;
  logic [7:0]              trapEvent, trapClr, trapFlags;
  logic [15:0]             interruptControlTwo;
  logic [3:0]              cpuPriorityLevel;
  logic [IDX_W-1:0]        tblWrIdx;
  logic [ADDR_W-1:0]       tblWrData, vecAddr, vecEntry;
  vic_take_t               takenVectorStatus;
  int                      failures = 0;
  int                      checks = 0;
  localparam logic [23:0]  DEF_HDL = 24'h0003F0;  // Default handler address

  initial forever #2 sys_clk = ~sys_clk;

  vic_controller vic_controller_inst (.sys_clk(sys_clk), .nrst(nrst), .srcEvent(srcEvent),
    .extPin(extPin), .flagClr(flagClr), .srcEnable(srcEnable), .srcPriority(srcPriority),
    .trapEvent(trapEvent), .trapClr(trapClr), .interruptControlTwo(interruptControlTwo),
    .cpuPriorityLevel(cpuPriorityLevel), .cpuAck(cpuAck), .retReq(retReq), .tblWrEn(tblWrEn),
    .tblWrIdx(tblWrIdx), .tblWrData(tblWrData), .intReq(intReq), .vecValid(vecValid),
    .vecAddr(vecAddr), .vecEntry(vecEntry), .retDone(retDone), .takenVectorStatus(takenVectorStatus),
    .requestFlagRegs(requestFlagRegs), .trapFlags(trapFlags));

  vic_cpu_model cpu_inst (.sys_clk(sys_clk), .intReq(intReq), .vecValid(vecValid),
    .retDone(retDone), .cpuAck(cpuAck), .retReq(retReq));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Entry contents: a distinct handler per used slot, the default elsewhere
  function automatic logic [23:0] ent(input logic alt, input int v);
    logic used;
    used = (v < NUM_TRAP) ? TRAP_IMPL[v] : IRQ_IMPL[v-NUM_TRAP];
    return used ? {8'h40, 7'h00, alt, 1'b0, v[6:0]} : DEF_HDL;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic level(input logic [3:0] l);
    @(posedge sys_clk);
    cpuPriorityLevel <= l;
  endtask

  // Enable request n at priority p and pulse its event once
  task automatic raise(input int n, input logic [2:0] p);
    @(posedge sys_clk);
    srcEnable[n]   <= 1'b1;
    srcPriority[n] <= p;
    srcEvent[n]    <= 1'b1;
    @(posedge sys_clk);
    srcEvent[n]    <= 1'b0;
  endtask

  task automatic clear_all;
    @(posedge sys_clk);
    flagClr <= '1;
    trapClr <= '1;
    @(posedge sys_clk);
    flagClr <= '0;
    trapClr <= '0;
  endtask

  // Both tables in one pass; memory is not reset so this precedes any take
  task automatic fill_table;
    for (int i = 0; i < 2*NUM_VEC; i++) begin
      @(posedge sys_clk);
      tblWrEn   <= 1'b1;
      tblWrIdx  <= {i >= NUM_VEC, 7'(i % NUM_VEC)};
      tblWrData <= ent(i >= NUM_VEC, i % NUM_VEC);
    end
    @(posedge sys_clk);
    tblWrEn <= 1'b0;
  endtask

  // Take the pending winner, expect vector v at level lvl, clear it and return
  task automatic serve(input int v, input logic [3:0] lvl, input logic alt, input int dly);
    int lat;
    @(posedge sys_clk);
    interruptControlTwo <= {alt, 15'h0000};
    tick(3);
    cpu_inst.take(dly, lat);
    `vic_chk(lat, ENTRY_CYC)
    `vic_chk(takenVectorStatus.taken_vector_number, 7'(v))
    `vic_chk(takenVectorStatus.level, lvl)
    `vic_chk(vecAddr, 24'h000004 + 24'(2*v) + (alt ? 24'h000100 : 24'h000000))
    `vic_chk(vecEntry, ent(alt, v))
    @(posedge sys_clk);
    if (v < NUM_TRAP) trapClr[v] <= 1'b1;
    else flagClr[v-NUM_TRAP] <= 1'b1;
    @(posedge sys_clk);
    trapClr <= '0;
    flagClr <= '0;
    cpu_inst.ret(lat);
    `vic_chk(lat, RET_CYC)
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Request gating by enable, priority and CPU level; flag persistence
  task automatic t_gate;
    raise(3, 3'd4);
    level(4'h4);
    tick(3);
    `vic_chk(intReq, 1'b0)
    level(4'h3);
    tick(3);
    `vic_chk(intReq, 1'b1)
    @(posedge sys_clk);
    srcEnable[3] <= 1'b0;
    tick(3);
    `vic_chk(intReq, 1'b0)
    @(posedge sys_clk);
    srcEnable[3]   <= 1'b1;
    srcPriority[3] <= 3'd7;
    level(4'h7);
    tick(3);
    `vic_chk(intReq, 1'b0)
    @(posedge sys_clk);
    srcPriority[3] <= 3'd0;
    level(4'h0);
    tick(3);
    `vic_chk(intReq, 1'b0)
    `vic_chk(requestFlagRegs[3], 1'b1)
    // Set and clear in the same cycle: the set must win
    @(posedge sys_clk);
    srcEvent[3] <= 1'b1;
    flagClr[3]  <= 1'b1;
    @(posedge sys_clk);
    srcEvent[3] <= 1'b0;
    tick(1);
    `vic_chk(requestFlagRegs[3], 1'b1)
    @(posedge sys_clk);
    flagClr[3] <= 1'b0;
    tick(1);
    `vic_chk(requestFlagRegs[3], 1'b0)
  endtask

  // Level first, then natural order within a level, one slow acknowledge
  task automatic t_order;
    raise(11, 3'd5);
    raise(2, 3'd5);
    raise(30, 3'd6);
    serve(38, 4'h6, 1'b0, 0);
    serve(10, 4'h5, 1'b0, 3);
    serve(19, 4'h5, 1'b0, 0);
  endtask

  // Vector numbering and both tables across the listed sources
  task automatic t_tables;
    int src[10] = '{0, 2, 3, 13, 16, 20, 29, 65, 72, 80};
    foreach (src[i]) begin
      raise(src[i], 3'(i % 7 + 1));
      serve(src[i] + 8, 4'(i % 7 + 1), 1'(i % 2), 0);
    end
    raise(1, 3'd7);
    tick(3);
    `vic_chk(requestFlagRegs[1], 1'b0)
    `vic_chk(intReq, 1'b0)
  endtask

  // Traps beat a top-priority user request, which CPU level 8 then masks
  task automatic t_traps;
    raise(3, 3'd7);
    for (int t = 0; t < 8; t++) begin
      @(posedge sys_clk);
      trapEvent[t] <= 1'b1;
      @(posedge sys_clk);
      trapEvent[t] <= 1'b0;
      tick(1);
      `vic_chk(trapFlags[t], 1'(t >= 1 && t <= 4))
      if (t >= 1 && t <= 4) serve(t, 4'h8, 1'(t == 3), 0);
    end
    level(4'h8);
    tick(3);
    `vic_chk(intReq, 1'b0)
    clear_all();
    level(4'h0);
  endtask

  // External pins reach their own request flags
  task automatic t_ext;
    int pin[3] = '{0, 20, 29};
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      extPin[k] <= 1'b1;
      tick(6);
      `vic_chk(requestFlagRegs[pin[k]], 1'b1)
      @(posedge sys_clk);
      extPin[k] <= 1'b0;
    end
    clear_all();
  endtask

  // Reset in mid-run clears flags, fetch address and taken status and leaves no request
  task automatic t_midreset;
    raise(3, 3'd4);
    tick(3);
    @(posedge sys_clk);
    nrst <= 1'b0;
    tick(1);
    `vic_chk(requestFlagRegs, {NUM_IRQ{1'b0}})
    `vic_chk(vecAddr, 24'h000000)
    `vic_chk(takenVectorStatus, 11'h000)
    @(posedge sys_clk);
    nrst <= 1'b1;
    tick(2);
    `vic_chk(intReq, 1'b0)
  endtask

  task automatic summarize;
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence: reset for three cycles, then every scenario in turn
  initial begin
    nrst = 1'b0;
    srcEvent = '0;
    flagClr = '0;
    srcEnable = '0;
    srcPriority = '0;
    extPin = '0;
    trapEvent = '0;
    trapClr = '0;
    interruptControlTwo = '0;
    cpuPriorityLevel = '0;
    tblWrEn = 1'b0;
    tblWrIdx = '0;
    tblWrData = '0;
    repeat (2) @(posedge sys_clk);
    tick(1);
    `vic_chk(intReq, 1'b0)
    `vic_chk(vecAddr, 24'h000000)
    @(posedge sys_clk);
    nrst <= 1'b1;
    fill_table();
    t_gate();
    t_order();
    t_tables();
    t_traps();
    t_ext();
    t_midreset();
    summarize();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #100us;
    failures++;
    summarize();
  end
endmodule
